//--- rtl/gcrr_regs.sv
// Global configuration and reset-control register bank
`timescale 1ns/1ps
module gcrr_regs
   import gcrr_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic              clk_en,
   input  wire gcrr_req_s         req,
   input  wire gcrr_load_s        otp_load,
   input  wire logic              otp_pgm_req,
   input  wire logic              dpll_enabled,
   output logic [7:0]             rdata,
   output logic                   rvalid,
   output logic                   otp_pgm_grant,
   output logic                   otp_pgm_refused,
   output logic                   ldo_high_sel,
   output logic [2:0]             osc_settle_wait_sel,
   output logic [3:0]             boot_profile_sel,
   output logic [GCRR_WAIT_US_W-1:0] settle_wait_us,
   output logic                   in_div_hold_b,
   output logic                   clk_out_oe,
   output logic                   out_div_sync,
   output logic                   fb_div_sync,
   output logic                   clk_squelch,
   output logic                   synth_restart
);

   // Settle wait decode, code 7 maps to the 1 ms default
   function automatic logic [GCRR_WAIT_US_W-1:0] wait_us(input logic [2:0] code);
      logic [GCRR_WAIT_US_W-1:0] us;
      us = 15'd1000;
      unique case (code)
         3'h0: us = 15'd1000;
         3'h1: us = 15'd2500;
         3'h2: us = 15'd5000;
         3'h3: us = 15'd7500;
         3'h4: us = 15'd10000;
         3'h5: us = 15'd500;
         3'h6: us = 15'd15000;
         3'h7: us = 15'd1000;
      endcase
      return us;
   endfunction : wait_us

   // Address hit decode used by write and read paths
   function automatic logic hit(input gcrr_req_s r, input logic [7:0] a);
      return r.addr == a;
   endfunction : hit

   typedef enum logic [1:0] {GCRR_IDLE, GCRR_SQUELCH} gcrr_sq_e;

   logic [15:0] tag_reg, tag_next;
   logic [7:0]  cfg_reg, cfg_next;
   logic [7:0]  lock_reg, lock_next;
   logic [7:0]  rst_reg, rst_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic        rvalid_reg, rvalid_next;
   logic        grant_reg, grant_next;
   logic        refuse_reg, refuse_next;
   logic        sync_reg, sync_next;
   logic        fb_reg, fb_next;
   logic        restart_reg, restart_next;
   logic [GCRR_WAIT_US_W-1:0] wait_reg, wait_next;
   gcrr_sq_e    sq_reg, sq_next;
   logic [GCRR_CNT_W-1:0] cnt_reg, cnt_next;
   logic        squelch_reg, squelch_next;
   logic        sync_rise, reinit_rise;
   logic [7:0]  rst_wr;

   // Register writes and trigger edge detection
   always_comb
   begin
      tag_next  = tag_reg;
      cfg_next  = cfg_reg;
      lock_next = lock_reg;
      rst_next  = rst_reg;
      rst_wr    = (req.wdata & GCRR_RST_MASK);
      sync_rise   = 1'b0;
      reinit_rise = 1'b0;
      if (otp_load.valid)
         tag_next = otp_load.tag;
      if (req.wr)
      begin
         if (hit(req, GCRR_ADDR_TAG_LO))
            tag_next[7:0] = req.wdata;
         if (hit(req, GCRR_ADDR_TAG_HI))
            tag_next[15:8] = req.wdata;
         if (hit(req, GCRR_ADDR_CFG))
            cfg_next = req.wdata & GCRR_CFG_MASK;
         if (hit(req, GCRR_ADDR_LOCK))
            lock_next = lock_reg | (req.wdata & GCRR_LOCK_MASK);
         if (hit(req, GCRR_ADDR_RST))
         begin
            rst_next = rst_wr;
            sync_rise   = rst_wr[GCRR_RST_SYNC_BIT] & ~rst_reg[GCRR_RST_SYNC_BIT];
            reinit_rise = rst_wr[GCRR_RST_REINIT_BIT] & ~rst_reg[GCRR_RST_REINIT_BIT];
         end
      end
   end

   // Read path, one cycle latency
   always_comb
   begin
      rdata_next  = 8'h00;
      rvalid_next = req.rd;
      if (req.rd)
      begin
         if (hit(req, GCRR_ADDR_TAG_LO))
            rdata_next = tag_reg[7:0];
         else if (hit(req, GCRR_ADDR_TAG_HI))
            rdata_next = tag_reg[15:8];
         else if (hit(req, GCRR_ADDR_CFG))
            rdata_next = cfg_reg;
         else if (hit(req, GCRR_ADDR_LOCK))
            rdata_next = lock_reg & GCRR_LOCK_MASK;
         else if (hit(req, GCRR_ADDR_RST))
            rdata_next = rst_reg & GCRR_RST_MASK;
      end
   end

   // Fuse programming gate and trigger pulses
   always_comb
   begin
      grant_next   = otp_pgm_req & ~lock_reg[GCRR_LOCK_BIT];
      refuse_next  = otp_pgm_req & lock_reg[GCRR_LOCK_BIT];
      sync_next    = sync_rise | reinit_rise;
      fb_next      = (sync_rise | reinit_rise) & dpll_enabled;
      restart_next = reinit_rise;
      wait_next    = wait_us(cfg_reg[GCRR_CFG_WAIT_LSB +: 3]);
   end

   // Squelch window state
   always_comb
   begin
      sq_next      = sq_reg;
      cnt_next     = cnt_reg;
      squelch_next = squelch_reg;
      unique case (sq_reg)
         GCRR_IDLE:
         begin
            if (sync_rise | reinit_rise)
            begin
               sq_next      = GCRR_SQUELCH;
               cnt_next     = GCRR_CNT_W'(GCRR_SQUELCH_CYC - 1);
               squelch_next = 1'b1;
            end
         end
         GCRR_SQUELCH:
         begin
            if (sync_rise | reinit_rise)
               cnt_next = GCRR_CNT_W'(GCRR_SQUELCH_CYC - 1);
            else if (cnt_reg == '0)
            begin
               sq_next      = GCRR_IDLE;
               squelch_next = 1'b0;
            end
            else
               cnt_next = cnt_reg - 1'b1;
         end
         default:
         begin
            sq_next      = GCRR_IDLE;
            squelch_next = 1'b0;
         end
      endcase
   end

   // State registers
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         tag_reg     <= GCRR_TAG_RST;
         cfg_reg     <= GCRR_CFG_RST;
         lock_reg    <= GCRR_LOCK_RST;
         rst_reg     <= GCRR_RST_RST;
         rdata_reg   <= 8'h00;
         rvalid_reg  <= 1'b0;
         grant_reg   <= 1'b0;
         refuse_reg  <= 1'b0;
         sync_reg    <= 1'b0;
         fb_reg      <= 1'b0;
         restart_reg <= 1'b0;
         wait_reg    <= 15'd1000;
         sq_reg      <= GCRR_IDLE;
         cnt_reg     <= '0;
         squelch_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         tag_reg     <= tag_next;
         cfg_reg     <= cfg_next;
         lock_reg    <= lock_next;
         rst_reg     <= rst_next;
         rdata_reg   <= rdata_next;
         rvalid_reg  <= rvalid_next;
         grant_reg   <= grant_next;
         refuse_reg  <= refuse_next;
         sync_reg    <= sync_next;
         fb_reg      <= fb_next;
         restart_reg <= restart_next;
         wait_reg    <= wait_next;
         sq_reg      <= sq_next;
         cnt_reg     <= cnt_next;
         squelch_reg <= squelch_next;
      end
   end

   // Outputs straight from flops
   assign rdata               = rdata_reg;
   assign rvalid              = rvalid_reg;
   assign otp_pgm_grant       = grant_reg;
   assign otp_pgm_refused     = refuse_reg;
   assign ldo_high_sel        = cfg_reg[GCRR_CFG_LDO_BIT];
   assign osc_settle_wait_sel = cfg_reg[GCRR_CFG_WAIT_LSB +: 3];
   assign boot_profile_sel    = cfg_reg[GCRR_CFG_SEL_LSB +: 4];
   assign settle_wait_us      = wait_reg;
   assign in_div_hold_b       = rst_reg[GCRR_RST_HOLD_BIT];
   assign clk_out_oe          = rst_reg[GCRR_RST_OE_BIT];
   assign out_div_sync        = sync_reg;
   assign fb_div_sync         = fb_reg;
   assign clk_squelch         = squelch_reg;
   assign synth_restart       = restart_reg;

   // Checks
   chk_lock_refuse: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_en && otp_pgm_req && lock_reg[GCRR_LOCK_BIT] |=> otp_pgm_refused && !otp_pgm_grant)
      else $error("fuse programming granted while locked");
   chk_lock_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
      lock_reg[GCRR_LOCK_BIT] |=> lock_reg[GCRR_LOCK_BIT])
      else $error("lock bit cleared without reset");
   chk_lock_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_en && req.wr && req.addr == GCRR_ADDR_LOCK && req.wdata[GCRR_LOCK_BIT]
      |=> lock_reg[GCRR_LOCK_BIT])
      else $error("lock bit not set by write");
   chk_sync_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_en && sync_rise |=> out_div_sync && (fb_div_sync == $past(dpll_enabled)))
      else $error("divider sync pulse missing");
   chk_squelch_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_en && (sync_rise || reinit_rise)
      |=> clk_squelch && cnt_reg == GCRR_CNT_W'(GCRR_SQUELCH_CYC - 1))
      else $error("squelch did not start");
   chk_restart_sync: assert property (@(posedge ref_clk) disable iff (!rst_b)
      synth_restart |-> out_div_sync && clk_squelch)
      else $error("restart without divider sync");
   chk_no_retrigger: assert property (@(posedge ref_clk) disable iff (!rst_b)
      rst_reg[GCRR_RST_SYNC_BIT] && $stable(rst_reg) |=> !out_div_sync || $past(reinit_rise))
      else $error("sync fired without fresh rising write");
   chk_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (rst_reg & ~GCRR_RST_MASK) == 8'h00 && (lock_reg & ~GCRR_LOCK_MASK) == 8'h00)
      else $error("reserved bits set");
endmodule : gcrr_regs

//--- rtl/gcrr_pkg.sv
// Package: offsets, fields, reset values and timing for global config registers
// Summary of operation
// - 16-bit writable factory tag loaded at start-up from fuse common area.
// - Tag value zero means nothing programmed; reset value is zero.
// - Config bit 7 picks regulator level 1.25V or 1.32V, resets to 0.
// - Three-bit settle-wait field codes 0..6 pick crystal wait; code 7 reserved.
// - Four-bit boot profile select picks stored configuration; resets to 4.
// - While lock bit is 1, every fuse programming attempt is refused.
// - Lock bit is set-only; writing 0 leaves it unchanged.
// - Lock bit clears only through power-on reset.
// - Divider hold bit, active low, reset 1, holds both input dividers set.
// - Output drive allow bit, reset 1, drives clock output enable directly.
// - Writing 1 to align trigger syncs output dividers, and PLL feedback if enabled; the code acts only if the bit was 0 before.
// - During divider synchronization all output clocks are squelched about 10us.
// - Writing 1 to restart trigger restarts start-up from calibration, with sync; the code acts only if the bit was 0 before.
package gcrr_pkg;
   // Register byte addresses, chosen layout
   localparam logic [7:0] GCRR_ADDR_TAG_LO = 8'h00;
   localparam logic [7:0] GCRR_ADDR_TAG_HI = 8'h01;
   localparam logic [7:0] GCRR_ADDR_CFG    = 8'h02;
   localparam logic [7:0] GCRR_ADDR_LOCK   = 8'h03;
   localparam logic [7:0] GCRR_ADDR_RST    = 8'h04;
   // Field positions
   localparam int GCRR_CFG_LDO_BIT   = 7;
   localparam int GCRR_CFG_WAIT_LSB  = 4;
   localparam int GCRR_CFG_SEL_LSB   = 0;
   localparam int GCRR_LOCK_BIT      = 7;
   localparam int GCRR_RST_HOLD_BIT  = 5;
   localparam int GCRR_RST_OE_BIT    = 4;
   localparam int GCRR_RST_SYNC_BIT  = 1;
   localparam int GCRR_RST_REINIT_BIT = 0;
   // Writable masks, reserved bits excluded
   localparam logic [7:0] GCRR_CFG_MASK  = 8'hff;
   localparam logic [7:0] GCRR_LOCK_MASK = 8'h80;
   localparam logic [7:0] GCRR_RST_MASK  = 8'h33;
   // Reset values, and the reserved settle-wait code
   localparam logic [15:0] GCRR_TAG_RST  = 16'h0000;
   localparam logic [7:0]  GCRR_CFG_RST  = 8'h04;
   localparam logic [7:0]  GCRR_LOCK_RST = 8'h00;
   localparam logic [7:0]  GCRR_RST_RST  = 8'h30;
   localparam logic [2:0]  GCRR_WAIT_RSVD = 3'h7;
   // Squelch timing
   localparam int GCRR_CLK_MHZ     = 200;
   localparam int GCRR_SQUELCH_US  = 10;
   localparam int GCRR_SQUELCH_CYC = GCRR_SQUELCH_US * GCRR_CLK_MHZ;
   localparam int GCRR_CNT_W       = 12;
   // Width of settle wait times in microseconds
   localparam int GCRR_WAIT_US_W = 15;
   // Register read and write request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gcrr_req_s;
   // Start-up load from fuse common area
   typedef struct packed {
      logic        valid;
      logic [15:0] tag;
   } gcrr_load_s;
endpackage : gcrr_pkg

//--- tb/tb_top.sv
// Self-checking bench for the global config and reset-control register bank
`timescale 1ns/1ps
module tb_top;
   import gcrr_pkg::*;
   logic                      ref_clk;
   logic                      rst_b;
   logic                      clk_en;
   gcrr_req_s                 req;
   gcrr_load_s                otp_load;
   logic                      otp_pgm_req;
   logic                      dpll_enabled;
   logic [7:0]                rdata;
   logic                      rvalid;
   logic                      otp_pgm_grant;
   logic                      otp_pgm_refused;
   logic                      ldo_high_sel;
   logic [2:0]                osc_settle_wait_sel;
   logic [3:0]                boot_profile_sel;
   logic [GCRR_WAIT_US_W-1:0] settle_wait_us;
   logic                      in_div_hold_b;
   logic                      clk_out_oe;
   logic                      out_div_sync;
   logic                      fb_div_sync;
   logic                      clk_squelch;
   logic                      synth_restart;
   int                        mismatches;
   int                        num_checks;
   logic [15:0]               wait_tab [8] = '{16'h03e8, 16'h09c4, 16'h1388, 16'h1d4c,
                                               16'h2710, 16'h01f4, 16'h3a98, 16'h03e8};

   gcrr_regs dut_u (
      .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .req(req), .otp_load(otp_load),
      .otp_pgm_req(otp_pgm_req), .dpll_enabled(dpll_enabled), .rdata(rdata),
      .rvalid(rvalid), .otp_pgm_grant(otp_pgm_grant), .otp_pgm_refused(otp_pgm_refused),
      .ldo_high_sel(ldo_high_sel), .osc_settle_wait_sel(osc_settle_wait_sel),
      .boot_profile_sel(boot_profile_sel), .settle_wait_us(settle_wait_us),
      .in_div_hold_b(in_div_hold_b), .clk_out_oe(clk_out_oe),
      .out_div_sync(out_div_sync), .fb_div_sync(fb_div_sync),
      .clk_squelch(clk_squelch), .synth_restart(synth_restart));

   // Clock at 200 MHz
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // Reset held ten cycles
   task automatic do_reset;
      @(posedge ref_clk);
      #1 rst_b = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1 rst_b = 1'b1;
   endtask : do_reset

   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      #1 req.wr = 1'b0;
   endtask : wr

   // One-cycle register read, data checked with rvalid
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      #1 req.rd = 1'b0;
      check({15'h0000, rvalid}, 16'h0001);
      check({8'h00, rdata}, {8'h00, exp});
   endtask : rd

   // Fuse programming attempt, grant or refusal
   task automatic pgm(input logic grant);
      @(posedge ref_clk);
      #1 otp_pgm_req = 1'b1;
      @(posedge ref_clk);
      #1 otp_pgm_req = 1'b0;
      check({14'h0000, otp_pgm_grant, otp_pgm_refused}, {14'h0000, grant, ~grant});
   endtask : pgm

   task automatic t_reset_values;
      rd(GCRR_ADDR_TAG_LO, 8'h00);
      rd(GCRR_ADDR_TAG_HI, 8'h00);
      rd(GCRR_ADDR_CFG, 8'h04);
      rd(GCRR_ADDR_LOCK, 8'h00);
      rd(GCRR_ADDR_RST, 8'h30);
      rd(8'h3c, 8'h00);
      check({8'h00, ldo_high_sel, osc_settle_wait_sel, boot_profile_sel}, 16'h0004);
      check({1'b0, settle_wait_us}, 16'h03e8);
      check({14'h0000, in_div_hold_b, clk_out_oe}, 16'h0003);
   endtask : t_reset_values

   task automatic t_tag;
      @(posedge ref_clk);
      #1 otp_load = '{valid: 1'b1, tag: 16'ha5c3};
      @(posedge ref_clk);
      #1 otp_load.valid = 1'b0;
      rd(GCRR_ADDR_TAG_LO, 8'hc3);
      rd(GCRR_ADDR_TAG_HI, 8'ha5);
      wr(GCRR_ADDR_TAG_HI, 8'h5e);
      rd(GCRR_ADDR_TAG_HI, 8'h5e);
      rd(GCRR_ADDR_TAG_LO, 8'hc3);
   endtask : t_tag

   task automatic t_cfg;
      for (int c = 0; c < 8; c++)
      begin
         wr(GCRR_ADDR_CFG, {c[0], c[2:0], 4'h9});
         check({12'h000, ldo_high_sel, osc_settle_wait_sel}, {12'h000, c[0], c[2:0]});
         check({12'h000, boot_profile_sel}, 16'h0009);
         // Decoded wait is registered one cycle behind the field
         @(posedge ref_clk);
         #1 check({1'b0, settle_wait_us}, wait_tab[c]);
      end
      // Frozen while clock enable is low
      clk_en = 1'b0;
      wr(GCRR_ADDR_CFG, 8'h00);
      clk_en = 1'b1;
      rd(GCRR_ADDR_CFG, 8'hf9);
   endtask : t_cfg

   task automatic t_lock;
      pgm(1'b1);
      wr(GCRR_ADDR_LOCK, 8'h7f);
      rd(GCRR_ADDR_LOCK, 8'h00);
      wr(GCRR_ADDR_LOCK, 8'hff);
      rd(GCRR_ADDR_LOCK, 8'h80);
      wr(GCRR_ADDR_LOCK, 8'h00);
      rd(GCRR_ADDR_LOCK, 8'h80);
      pgm(1'b0);
      do_reset();
      rd(GCRR_ADDR_LOCK, 8'h00);
      pgm(1'b1);
   endtask : t_lock

   task automatic t_triggers;
      int cnt;
      dpll_enabled = 1'b1;
      wr(GCRR_ADDR_RST, 8'h32);
      check({13'h0000, out_div_sync, fb_div_sync, synth_restart}, 16'h0006);
      cnt = 0;
      while (clk_squelch === 1'b1 && cnt < 3000)
      begin
         cnt++;
         @(posedge ref_clk);
         #1;
      end
      check(cnt[15:0], GCRR_SQUELCH_CYC[15:0]);
      wr(GCRR_ADDR_RST, 8'h32);
      check({15'h0000, out_div_sync}, 16'h0000);
      wr(GCRR_ADDR_RST, 8'h30);
      dpll_enabled = 1'b0;
      wr(GCRR_ADDR_RST, 8'h32);
      check({13'h0000, out_div_sync, fb_div_sync, clk_squelch}, 16'h0005);
      wr(GCRR_ADDR_RST, 8'h31);
      check({14'h0000, out_div_sync, synth_restart}, 16'h0003);
      @(posedge ref_clk);
      #1 check({14'h0000, out_div_sync, synth_restart}, 16'h0000);
      wr(GCRR_ADDR_RST, 8'h31);
      check({15'h0000, synth_restart}, 16'h0000);
      wr(GCRR_ADDR_RST, 8'h00);
      check({14'h0000, in_div_hold_b, clk_out_oe}, 16'h0000);
      wr(GCRR_ADDR_RST, 8'hff);
      rd(GCRR_ADDR_RST, 8'h33);
      check({14'h0000, in_div_hold_b, clk_out_oe}, 16'h0003);
   endtask : t_triggers

   // Watchdog on a hang
   initial
   begin
      #200000;
      mismatches++;
      final_report();
   end

   initial
   begin
      mismatches = 0;
      num_checks = 0;
      rst_b = 1'b0;
      clk_en = 1'b1;
      req = '0;
      otp_load = '0;
      otp_pgm_req = 1'b0;
      dpll_enabled = 1'b0;
      do_reset();
      t_reset_values();
      t_tag();
      t_cfg();
      t_lock();
      t_triggers();
      final_report();
   end
endmodule : tb_top
